// file: shared/uart_map.vh
`ifndef EMU_UART_MAP_VH
`define EMU_UART_MAP_VH

// Register byte offsets
`define A_CTRL 8'h00
`define A_BAUD 8'h04
`define A_PINSEL 8'h08
`define A_TXDATA 8'h0C
`define A_RXDATA 8'h10
`define A_STATUS 8'h14

// Control fields
`define CTRL_TXEN 0
`define CTRL_RXEN 1
`define CTRL_DATA8 2
`define CTRL_STOP2 3
`define CTRL_CTSEN 4
`define CTRL_W 5
`define CTRL_RST 5'h04

// Pin select fields
`define PS_RX_LO 0
`define PS_RX_HI 1
`define PS_TX_LO 8
`define PS_TX_HI 12
`define PS_CTS_LO 16
`define PS_CTS_HI 20
`define PS_RX_RST 2'h0
`define PS_TX_RST 5'h00
`define PS_CTS_RST 5'h01

// Receive pin candidates
`define RX_PIN0 5'h06
`define RX_PIN1 5'h10
`define RX_PIN2 5'h14

// Status fields
`define ST_TXFULL 0
`define ST_TXEMPTY 1
`define ST_RXVALID 2
`define ST_OVERRUN 3
`define ST_FRAMERR 4
`define ST_TXBUSY 5

// Pins, FIFO, timing
`define NPINS 21
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define OVS_LAST 4'hF
`define OVS_MID 4'h7
`define CLK_HZ 100000000
`define MAX_BAUD 115200
`define MIN_DIV (`CLK_HZ / (`MAX_BAUD * 16) - 1)
`define BAUD_W 16
`define BAUD_RST 16'h0035

`endif

// file: logic/emulated_full_duplex_uart.v
// How it works
// [R01] Independent transmitter and receiver run concurrently
// [R02] One setting picks seven or eight data bits
// [R03] No parity; one or two stop bits
// [R04] Programmable rate, capped at 115200 baud
// [R05] Receive on three pins; transmit/CTS any
// [R06] Start low, LSB first, stop high; CTS pauses
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "uart_map.vh"

module uart_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] count_r;
    wire push;
    wire pop;

    // Honest full and empty from the occupancy count
    assign in_ready = (count_r != DEPTH[AW:0]);
    assign out_valid = (count_r != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage write
    always @(posedge clk)
    begin
        if (push)
            mem[wr_ptr_r] <= in_data;
    end

    // Pointers and count
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
            if (push && !pop)
                count_r <= count_r + 1'b1;
            else if (pop && !push)
                count_r <= count_r - 1'b1;
        end
    end
endmodule

module emulated_full_duplex_uart (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [`NPINS-1:0] io_handler_pin_in,
    output wire [`NPINS-1:0] io_handler_pin_out,
    output wire [`NPINS-1:0] io_handler_pin_oe
);
    localparam T_IDLE = 2'h0;
    localparam T_START = 2'h1;
    localparam T_DATA = 2'h2;
    localparam T_STOP = 2'h3;
    localparam R_IDLE = 2'h0;
    localparam R_START = 2'h1;
    localparam R_DATA = 2'h2;
    localparam R_STOP = 2'h3;

    // Pick one handler pin; an index past the last pin reads idle high
    function pick_pin;
        input [`NPINS-1:0] vec;
        input [4:0] idx;
        begin
            if (idx < `NPINS)
                pick_pin = vec[idx];
            else
                pick_pin = 1'b1;
        end
    endfunction

    // Last data bit index for the selected character length
    function [2:0] last_bit;
        input data8;
        begin
            last_bit = data8 ? 3'h7 : 3'h6;
        end
    endfunction

    reg [`CTRL_W-1:0] ctrl_r;
    reg [`BAUD_W-1:0] baud_r;
    reg [1:0] rx_sel_r;
    reg [4:0] tx_pin_r;
    reg [4:0] cts_pin_r;
    reg overrun_r;
    reg framerr_r;
    reg [`BAUD_W-1:0] div_cnt_r;
    reg tick_r;
    reg [1:0] tx_state_r;
    reg [3:0] tx_ovs_r;
    reg [2:0] tx_bit_r;
    reg [7:0] tx_sh_r;
    reg tx_line_r;
    reg tx_stop2_r;
    reg [1:0] rx_state_r;
    reg [3:0] rx_ovs_r;
    reg [2:0] rx_bit_r;
    reg [7:0] rx_sh_r;
    reg rx_stop2_r;
    reg rx_push_r;
    reg [7:0] rx_word_r;
    reg rx_hold_r;

    wire setup = psel && !penable;
    wire access = psel && penable;
    wire a_ctrl = (paddr == `A_CTRL);
    wire a_baud = (paddr == `A_BAUD);
    wire a_pinsel = (paddr == `A_PINSEL);
    wire a_txdata = (paddr == `A_TXDATA);
    wire a_rxdata = (paddr == `A_RXDATA);
    wire a_status = (paddr == `A_STATUS);
    wire mapped = a_ctrl | a_baud | a_pinsel | a_txdata | a_rxdata | a_status;
    wire txen = ctrl_r[`CTRL_TXEN];
    wire rxen = ctrl_r[`CTRL_RXEN];
    wire data8 = ctrl_r[`CTRL_DATA8];
    wire stop2 = ctrl_r[`CTRL_STOP2];
    wire ctsen = ctrl_r[`CTRL_CTSEN];
    wire tx_in_ready;
    wire tx_out_valid;
    wire [7:0] tx_out_data;
    wire rx_in_ready;
    wire rx_out_valid;
    wire [7:0] rx_out_data;
    wire tx_stall;
    wire tx_wr;
    wire rx_rd;
    wire wr_done;
    wire [`BAUD_W-1:0] eff_div;
    wire cts_high;
    wire tx_pop;
    reg [4:0] rx_pin;
    wire rx_line;

    // Writes to a full transmit FIFO stall the bus while the transmitter is enabled; with it disabled they get an error
    assign tx_stall = access && pwrite && a_txdata && txen && !tx_in_ready;
    assign pready = !tx_stall;
    assign pslverr = access && (!mapped || (pwrite && a_txdata && !txen && !tx_in_ready));
    assign wr_done = access && pwrite && pready;
    assign tx_wr = wr_done && a_txdata && tx_in_ready;
    assign rx_rd = access && !pwrite && a_rxdata && rx_hold_r;

    uart_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) tx_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .in_valid(tx_wr),
        .in_ready(tx_in_ready),
        .in_data(pwdata[7:0]),
        .out_valid(tx_out_valid),
        .out_ready(tx_pop),
        .out_data(tx_out_data)
    );

    uart_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) rx_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .in_valid(rx_push_r),
        .in_ready(rx_in_ready),
        .in_data(rx_word_r),
        .out_valid(rx_out_valid),
        .out_ready(rx_rd),
        .out_data(rx_out_data)
    );

    // Register writes and sticky error flags; a new error beats a clear
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= `CTRL_RST;
            baud_r <= `BAUD_RST;
            rx_sel_r <= `PS_RX_RST;
            tx_pin_r <= `PS_TX_RST;
            cts_pin_r <= `PS_CTS_RST;
            overrun_r <= 1'b0;
            framerr_r <= 1'b0;
        end
        else
        begin
            if (wr_done && a_ctrl)
                ctrl_r <= pwdata[`CTRL_W-1:0];
            if (wr_done && a_baud)
                baud_r <= pwdata[`BAUD_W-1:0];
            if (wr_done && a_pinsel)
            begin
                rx_sel_r <= pwdata[`PS_RX_HI:`PS_RX_LO];
                tx_pin_r <= pwdata[`PS_TX_HI:`PS_TX_LO];
                cts_pin_r <= pwdata[`PS_CTS_HI:`PS_CTS_LO];
            end
            overrun_r <= (overrun_r & ~(wr_done && a_status && pwdata[`ST_OVERRUN]))
                | (rx_push_r && !rx_in_ready);
            framerr_r <= (framerr_r & ~(wr_done && a_status && pwdata[`ST_FRAMERR]))
                | (rx_state_r == R_STOP && tick_r && rx_ovs_r == `OVS_LAST && !rx_line);
        end
    end

    // Read data captured in the setup cycle; a word landing after capture is not popped
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            rx_hold_r <= 1'b0;
        end
        else if (setup && !pwrite)
        begin
            prdata <= 32'h00000000;
            rx_hold_r <= a_rxdata && rx_out_valid;
            if (a_ctrl)
                prdata[`CTRL_W-1:0] <= ctrl_r;
            if (a_baud)
                prdata[`BAUD_W-1:0] <= baud_r;
            if (a_pinsel)
            begin
                prdata[`PS_RX_HI:`PS_RX_LO] <= rx_sel_r;
                prdata[`PS_TX_HI:`PS_TX_LO] <= tx_pin_r;
                prdata[`PS_CTS_HI:`PS_CTS_LO] <= cts_pin_r;
            end
            if (a_rxdata)
                prdata[7:0] <= rx_out_valid ? rx_out_data : 8'h00;
            if (a_status)
            begin
                prdata[`ST_TXFULL] <= !tx_in_ready;
                prdata[`ST_TXEMPTY] <= !tx_out_valid;
                prdata[`ST_RXVALID] <= rx_out_valid;
                prdata[`ST_OVERRUN] <= overrun_r;
                prdata[`ST_FRAMERR] <= framerr_r;
                prdata[`ST_TXBUSY] <= (tx_state_r != T_IDLE);
            end
        end
    end

    // Sixteen-times oversampling tick, divisor held at or above the fastest rate
    wire [31:0] min_div_full = `MIN_DIV;
    assign eff_div = (baud_r < min_div_full[`BAUD_W-1:0]) ? min_div_full[`BAUD_W-1:0] : baud_r; // [R04]
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt_r <= {`BAUD_W{1'b0}};
            tick_r <= 1'b0;
        end
        else if (div_cnt_r >= eff_div)
        begin
            div_cnt_r <= {`BAUD_W{1'b0}};
            tick_r <= 1'b1;
        end
        else
        begin
            div_cnt_r <= div_cnt_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

    // Transmit pin routing: any handler pin drives out and CTS
    assign cts_high = pick_pin(io_handler_pin_in, cts_pin_r); // [R05]
    assign io_handler_pin_out = {`NPINS{tx_line_r}};
    assign io_handler_pin_oe = txen ? ({{(`NPINS-1){1'b0}}, 1'b1} << tx_pin_r) : {`NPINS{1'b0}}; // [R05]
    assign tx_pop = (tx_state_r == T_IDLE) && tick_r && txen && tx_out_valid && !(ctsen && cts_high); // [R06]

    // Transmitter: start, data LSB first, one or two stop bits
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_state_r <= T_IDLE;
            tx_ovs_r <= 4'h0;
            tx_bit_r <= 3'h0;
            tx_sh_r <= 8'h00;
            tx_line_r <= 1'b1;
            tx_stop2_r <= 1'b0;
        end
        else if (tick_r)
        begin
            tx_ovs_r <= tx_ovs_r + 1'b1;
            case (tx_state_r)
                T_IDLE:
                begin
                    tx_line_r <= 1'b1;
                    tx_ovs_r <= 4'h0;
                    if (tx_pop) // [R01]
                    begin
                        tx_sh_r <= tx_out_data;
                        tx_line_r <= 1'b0; // [R06]
                        tx_state_r <= T_START;
                    end
                end
                T_START:
                    if (tx_ovs_r == `OVS_LAST)
                    begin
                        tx_line_r <= tx_sh_r[0];
                        tx_sh_r <= {1'b0, tx_sh_r[7:1]}; // [R06]
                        tx_bit_r <= 3'h0;
                        tx_state_r <= T_DATA;
                    end
                T_DATA:
                    if (tx_ovs_r == `OVS_LAST)
                    begin
                        if (tx_bit_r == last_bit(data8)) // [R02]
                        begin
                            tx_line_r <= 1'b1; // [R03]
                            tx_stop2_r <= stop2;
                            tx_state_r <= T_STOP;
                        end
                        else
                        begin
                            tx_line_r <= tx_sh_r[0];
                            tx_sh_r <= {1'b0, tx_sh_r[7:1]};
                            tx_bit_r <= tx_bit_r + 1'b1;
                        end
                    end
                T_STOP:
                    if (tx_ovs_r == `OVS_LAST)
                    begin
                        if (tx_stop2_r) // [R03]
                            tx_stop2_r <= 1'b0;
                        else
                            tx_state_r <= T_IDLE;
                    end
                default:
                    tx_state_r <= T_IDLE;
            endcase
        end
    end

    // Receive pin: only three candidates
    always @*
    begin
        case (rx_sel_r)
            2'h0: rx_pin = `RX_PIN0; // [R05]
            2'h1: rx_pin = `RX_PIN1;
            2'h2: rx_pin = `RX_PIN2;
            default: rx_pin = 5'h1F;
        endcase
    end
    assign rx_line = pick_pin(io_handler_pin_in, rx_pin);

    // Receiver: verify start mid-bit, then sample each bit centre
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_state_r <= R_IDLE;
            rx_ovs_r <= 4'h0;
            rx_bit_r <= 3'h0;
            rx_sh_r <= 8'h00;
            rx_stop2_r <= 1'b0;
            rx_push_r <= 1'b0;
            rx_word_r <= 8'h00;
        end
        else
        begin
            rx_push_r <= 1'b0;
            if (tick_r)
            begin
                rx_ovs_r <= rx_ovs_r + 1'b1;
                case (rx_state_r)
                    R_IDLE:
                    begin
                        rx_ovs_r <= 4'h0;
                        if (rxen && !rx_line) // [R01]
                            rx_state_r <= R_START;
                    end
                    R_START:
                        if (rx_ovs_r == `OVS_MID)
                        begin
                            rx_ovs_r <= 4'h0;
                            rx_bit_r <= 3'h0;
                            rx_state_r <= rx_line ? R_IDLE : R_DATA; // [R06]
                        end
                    R_DATA:
                        if (rx_ovs_r == `OVS_LAST)
                        begin
                            rx_sh_r <= {rx_line, rx_sh_r[7:1]}; // [R06]
                            rx_bit_r <= rx_bit_r + 1'b1;
                            if (rx_bit_r == last_bit(data8)) // [R02]
                            begin
                                rx_stop2_r <= stop2;
                                rx_state_r <= R_STOP;
                            end
                        end
                    R_STOP:
                        if (rx_ovs_r == `OVS_LAST)
                        begin
                            if (!rx_line)
                                rx_state_r <= R_IDLE; // [R03]
                            else if (rx_stop2_r)
                                rx_stop2_r <= 1'b0; // [R03]
                            else
                            begin
                                rx_word_r <= data8 ? rx_sh_r : {1'b0, rx_sh_r[7:1]}; // [R02]
                                rx_push_r <= 1'b1;
                                rx_state_r <= R_IDLE;
                            end
                        end
                    default:
                        rx_state_r <= R_IDLE;
                endcase
            end
        end
    end
endmodule

// file: bench/uart_partner.sv
`timescale 1ns/100ps
// Far-side serial device: samples the transmit line, drives the receive line
module uart_partner (
    input wire clk,
    input wire tx_line,
    input wire data8,
    input wire stop2,
    output reg rx_line
);
    // Clocks per bit at the clamped fastest divisor
    localparam integer BIT_CLKS = 864;
    logic [7:0] got [$];
    integer bad = 0;
    integer i;
    logic [7:0] shift_r;

    initial rx_line = 1'b1;

    // One frame per falling edge, sampled in each bit centre
    always @(negedge tx_line)
    begin
        repeat (BIT_CLKS / 2) @(posedge clk);
        if (tx_line !== 1'b0) bad = bad + 1;
        shift_r = 8'h00;
        for (i = 0; i < (data8 ? 8 : 7); i = i + 1)
        begin
            repeat (BIT_CLKS) @(posedge clk);
            shift_r[i] = tx_line;
        end
        repeat (BIT_CLKS) @(posedge clk);
        if (tx_line !== 1'b1) bad = bad + 1;
        if (stop2)
        begin
            repeat (BIT_CLKS) @(posedge clk);
            if (tx_line !== 1'b1) bad = bad + 1;
        end
        got.push_back(shift_r);
    end

    // Sends one frame; a low first stop bit provokes a framing fault
    task automatic send(input [7:0] d, input bad_stop);
        integer k;
        begin
            rx_line <= 1'b0;
            repeat (BIT_CLKS) @(posedge clk);
            for (k = 0; k < (data8 ? 8 : 7); k = k + 1)
            begin
                rx_line <= d[k];
                repeat (BIT_CLKS) @(posedge clk);
            end
            rx_line <= ~bad_stop;
            repeat (BIT_CLKS) @(posedge clk);
            // Second stop bit, or one idle clock so back-to-back frames never assign twice at once
            rx_line <= 1'b1;
            repeat (stop2 ? BIT_CLKS : 1) @(posedge clk);
        end
    endtask
endmodule

// file: bench/uart_asserts.sv
`timescale 1ns/100ps
`include "uart_map.vh"
// Port-level checks on the bus answers and the shared pin drivers
module uart_asserts (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [`NPINS-1:0] io_handler_pin_in,
    input wire [`NPINS-1:0] io_handler_pin_out,
    input wire [`NPINS-1:0] io_handler_pin_oe
);
    // Address decode and access phase
    wire mapped = (paddr <= `A_STATUS) && (paddr[1:0] == 2'b00);
    wire acc = psel && penable;

    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_reset_pins: assert property ($rose(presetn) |-> (&io_handler_pin_out) && (io_handler_pin_oe == 0))
        else $error("pins not idle after reset");
    chk_one_driver: assert property ($onehot0(io_handler_pin_oe))
        else $error("more than one pin driven");
    chk_pins_agree: assert property (io_handler_pin_out == {`NPINS{io_handler_pin_out[0]}})
        else $error("pin outputs disagree");
    chk_start_width: assert property ($fell(io_handler_pin_out[0]) |-> !io_handler_pin_out[0] [*8])
        else $error("start bit too short");
    chk_bit_width: assert property ($rose(io_handler_pin_out[0]) |-> io_handler_pin_out[0] [*8])
        else $error("high bit too short");
    chk_ready_plain: assert property (acc && !(pwrite && paddr == `A_TXDATA) |-> pready)
        else $error("unexpected wait state");
    chk_unmapped_err: assert property (acc && !mapped |-> pslverr)
        else $error("unmapped access not refused");
    chk_mapped_read: assert property (acc && !pwrite && mapped |-> !pslverr)
        else $error("mapped read refused");
    chk_unmapped_zero: assert property (acc && !pwrite && !mapped |-> prdata == 32'h00000000)
        else $error("unmapped read not zero");
    chk_rdata_stands: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved");
endmodule

// file: bench/tb_top.sv
`timescale 1ns/100ps
`include "uart_map.vh"
module tb_top;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h00000000;
    reg cts_n = 1'b0;
    reg data8 = 1'b1;
    reg stop2 = 1'b0;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire rx_line;
    wire tx_line;
    wire [`NPINS-1:0] pin_out;
    wire [`NPINS-1:0] pin_oe;
    wire [`NPINS-1:0] pin_in;
    integer num_errors = 0;
    integer tests_run = 0;
    integer n;

    // Pin 3 carries transmit, pin 9 clear-to-send, pin 16 receive; undriven pins idle high
    assign tx_line = pin_oe[3] ? pin_out[3] : 1'b1;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & {4'hF, rx_line, 6'h3F, cts_n, 9'h1FF});

    always #5 pclk = ~pclk;

    emulated_full_duplex_uart dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .io_handler_pin_in(pin_in), .io_handler_pin_out(pin_out), .io_handler_pin_oe(pin_oe));
    uart_partner p (.clk(pclk), .tx_line(tx_line), .data8(data8), .stop2(stop2), .rx_line(rx_line));

    // Counts one comparison and reports a mismatch
    task chk(input [31:0] got, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp)
            begin
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
                num_errors = num_errors + 1;
            end
        end
    endtask

    // One APB transfer; masked read data and error flag are compared
    task apb(input [7:0] a, input w, input [31:0] d, input [31:0] m, input [31:0] x, input xe);
        integer k;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            k = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && k < 100000)
            begin
                k = k + 1;
                @(posedge pclk);
            end
            if (k >= 100000)
                num_errors = num_errors + 1;
            chk(prdata & m, x);
            chk({31'h0, pslverr}, {31'h0, xe});
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // Waits for the partner to have collected a number of characters
    task wait_rx(input integer cnt);
        integer k;
        begin
            k = 0;
            while (p.got.size() < cnt && k < 100000)
            begin
                k = k + 1;
                @(posedge pclk);
            end
            if (k >= 100000)
                num_errors = num_errors + 1;
        end
    endtask

    task close_out;
        begin
            if (num_errors == 0 && tests_run > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    // Cuts a hang short, with margin past the roughly 96k cycles the tests need
    initial
    begin
        repeat (110000) @(posedge pclk);
        num_errors = num_errors + 1;
        close_out;
    end

    // Main sequence
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(`A_CTRL, 1'b0, 32'h0, 32'hFFFFFFFF, 32'h00000004, 1'b0);
        apb(`A_BAUD, 1'b0, 32'h0, 32'hFFFFFFFF, 32'h00000035, 1'b0);
        apb(8'h40, 1'b0, 32'h0, 32'hFFFFFFFF, 32'h00000000, 1'b1);
        apb(`A_PINSEL, 1'b1, 32'h00090301, 32'h0, 32'h0, 1'b0);
        apb(`A_PINSEL, 1'b0, 32'h0, 32'hFFFFFFFF, 32'h00090301, 1'b0);
        for (n = 0; n < 8; n = n + 1)
            apb(`A_TXDATA, 1'b1, 32'h30 + n, 32'h0, 32'h0, 1'b0);
        apb(`A_TXDATA, 1'b1, 32'h99, 32'h0, 32'h0, 1'b1);
        apb(`A_STATUS, 1'b0, 32'h0, 32'h3, 32'h1, 1'b0);
        cts_n <= 1'b1;
        apb(`A_CTRL, 1'b1, 32'h17, 32'h0, 32'h0, 1'b0);
        repeat (1000) @(posedge pclk);
        chk({31'h0, tx_line}, 32'h1);
        apb(`A_STATUS, 1'b0, 32'h0, 32'h20, 32'h0, 1'b0);
        cts_n <= 1'b0;
        fork
            begin
                p.send(8'hA5, 1'b0);
                p.send(8'h3C, 1'b0);
            end
        join_none
        // FIFO still full while enabled: this write waits for a free slot and is not lost
        apb(`A_TXDATA, 1'b1, 32'h38, 32'h0, 32'h0, 1'b0);
        wait_rx(9);
        for (n = 0; n < 9; n = n + 1)
            chk({24'h0, p.got[n]}, 32'h30 + n);
        apb(`A_RXDATA, 1'b0, 32'h0, 32'hFFFFFFFF, 32'hA5, 1'b0);
        apb(`A_RXDATA, 1'b0, 32'h0, 32'hFFFFFFFF, 32'h3C, 1'b0);
        apb(`A_RXDATA, 1'b0, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b0);
        data8 <= 1'b0;
        stop2 <= 1'b1;
        apb(`A_CTRL, 1'b1, 32'h0B, 32'h0, 32'h0, 1'b0);
        apb(`A_TXDATA, 1'b1, 32'h55, 32'h0, 32'h0, 1'b0);
        p.send(8'h2A, 1'b0);
        wait_rx(10);
        chk({24'h0, p.got[9]}, 32'h55);
        apb(`A_RXDATA, 1'b0, 32'h0, 32'hFFFFFFFF, 32'h2A, 1'b0);
        p.send(8'h11, 1'b1);
        apb(`A_STATUS, 1'b0, 32'h0, 32'h14, 32'h10, 1'b0);
        apb(`A_STATUS, 1'b1, 32'h10, 32'h0, 32'h0, 1'b0);
        apb(`A_STATUS, 1'b0, 32'h0, 32'h10, 32'h0, 1'b0);
        chk(p.bad, 32'h0);
        close_out;
    end
endmodule

bind emulated_full_duplex_uart uart_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .io_handler_pin_in(io_handler_pin_in), .io_handler_pin_out(io_handler_pin_out),
    .io_handler_pin_oe(io_handler_pin_oe));
